// ==== core/usb_host_ctrl_defines.vh ====
`ifndef USB_HOST_CTRL_DEFINES_VH
`define USB_HOST_CTRL_DEFINES_VH

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_CMD 8'h04
`define OFS_SIGNAL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_INREQ 8'h10
`define OFS_INCLR 8'h14
`define OFS_CIE_SET 8'h18
`define OFS_CIE_CLR 8'h1c
`define OFS_EIE_SET 8'h20
`define OFS_EIE_CLR 8'h24
`define OFS_CIS 8'h28
`define OFS_EIS 8'h2c
`define OFS_INDATA 8'h30

// mode register fields
`define MODE_HOST_BIT 0
`define MODE_PFLT_EN_BIT 1
`define MODE_PFLT_POL_BIT 2

// command register (write-one actions)
`define CMD_STATUS_REQ_BIT 0
`define CMD_SUSPEND_BIT 1

// signalling register fields
`define SIG_RESET_BIT 0
`define SIG_RESUME_BIT 1

// control-group flag positions
`define CI_VBUS_ERR 0
`define CI_DISCONNECT 1
`define CI_CONNECT 2
`define CI_SOF 3
`define CI_BABBLE 4
`define CI_RESUME 5
`define CI_POWER_FAULT 6
`define CI_STATUS_DONE 7
`define CI_WIDTH 8

// endpoint-group: bit n is endpoint n
`define EP_COUNT 8

// speed codes
`define SPEED_UNKNOWN 2'h0
`define SPEED_LOW 2'h1
`define SPEED_FULL 2'h2
`define SPEED_HIGH 2'h3

// answer latency of the slave, in cycles
`define BUS_WAIT_CYCLES 2'h1

`endif

// ==== core/sync2.v ====
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
)(
  input wire sys_clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end
    else if (ce_i)
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ==== core/usb_host_ctrl.v ====
// Function
// - power fault input is watched only while software enables detection
// - software request in host mode queues an IN transaction on the chosen endpoint
// - returned IN data readable from endpoint buffer or DMA strobe
// - cancel withdraws a queued IN not yet carried out
// - status-phase IN request exists only on endpoint zero
// - status packet received raises control-group interrupt flag
// - reset drives on bus in host mode while start flag set; software holds 20ms
// - clearing resume start flag in host mode finishes resume sequence
// - speed of connected device reported low, full, high or unknown
// - suspend request in host mode suspends the bus
// - control-group enable mask set bit by bit
// - control-group enable bits cleared selectively, others untouched
// - endpoint enable mask set bit by bit
// - endpoint enable bits cleared selectively, control untouched
// - one combined interrupt line from enabled sources only
// - reading control status returns and clears pending control flags
// - reading endpoint status returns and clears pending endpoint flags
`timescale 1ns/1ps
`include "usb_host_ctrl_defines.vh"
module usb_host_ctrl (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire reset_i,
  input wire ce_i,
  // avalon-mm slave
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // pins from the bus side
  input wire power_fault_input_i,
  input wire [1:0] dev_speed_i,
  input wire dev_attach_i,
  input wire vbus_err_i,
  input wire babble_i,
  input wire remote_resume_i,
  // events from the transaction engine, same clock
  input wire sof_i,
  input wire [`EP_COUNT-1:0] in_done_i,
  input wire [31:0] in_data_i,
  input wire status_done_i,
  // requests toward the transaction engine
  output reg [`EP_COUNT-1:0] in_pending_o,
  output reg status_req_o,
  output reg bus_reset_o,
  output reg bus_resume_o,
  output reg bus_suspend_o,
  output reg dma_req_o,
  output reg [31:0] dma_data_o,
  output reg [1:0] speed_o,
  output reg irq_o
);
  // synchronised pins
  wire pflt_s;
  wire attach_s;
  wire vbus_s;
  wire babble_s;
  wire rres_s;
  wire [1:0] speed_s;

  sync2 #(.W(7)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .d_i({power_fault_input_i, dev_attach_i, vbus_err_i, babble_i,
      remote_resume_i, dev_speed_i}),
    .q_o({pflt_s, attach_s, vbus_s, babble_s, rres_s, speed_s})
  );

  reg host_mode_r;
  reg pflt_en_r;
  reg pflt_pol_r;
  reg reset_flag_r;
  reg resume_flag_r;
  reg [`CI_WIDTH-1:0] cie_r;
  reg [`EP_COUNT-1:0] eie_r;
  reg [`CI_WIDTH-1:0] cis_r;
  reg [`EP_COUNT-1:0] eis_r;
  reg [31:0] ep_buf_r [0:`EP_COUNT-1];
  reg [2:0] buf_sel_r;
  reg attach_d_r;
  reg pflt_d_r;
  reg vbus_d_r;
  reg rres_d_r;
  reg [1:0] resume_st_r;

  localparam RS_IDLE = 2'h0;
  localparam RS_DRIVE = 2'h1;
  localparam RS_FINISH = 2'h2;

  // avalon accesses are taken only at the cycle waitrequest is low
  wire acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  wire wr = acc & avs_write_i;
  wire rd = acc & avs_read_i;
  wire [31:0] wd = avs_writedata_i & {{8{avs_byteenable_i[3]}},
    {8{avs_byteenable_i[2]}}, {8{avs_byteenable_i[1]}},
    {8{avs_byteenable_i[0]}}};

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_mode = wr & hit(avs_address_i, `OFS_MODE);
  wire wr_cmd = wr & hit(avs_address_i, `OFS_CMD);
  wire wr_sig = wr & hit(avs_address_i, `OFS_SIGNAL);
  wire rd_cis = rd & hit(avs_address_i, `OFS_CIS);
  wire rd_eis = rd & hit(avs_address_i, `OFS_EIS);
  // one strobe per writable offset
  wire wr_inreq = wr & hit(avs_address_i, `OFS_INREQ);
  wire wr_inclr = wr & hit(avs_address_i, `OFS_INCLR);
  wire wr_cie_set = wr & hit(avs_address_i, `OFS_CIE_SET);
  wire wr_cie_clr = wr & hit(avs_address_i, `OFS_CIE_CLR);
  wire wr_eie_set = wr & hit(avs_address_i, `OFS_EIE_SET);
  wire wr_eie_clr = wr & hit(avs_address_i, `OFS_EIE_CLR);
  wire wr_indata = wr & hit(avs_address_i, `OFS_INDATA);

  // power fault level; polarity is selectable
  wire pflt_lvl = pflt_en_r & (pflt_s ^ pflt_pol_r);
  wire attach_rise = attach_s & ~attach_d_r;
  wire attach_fall = ~attach_s & attach_d_r;

  wire [`CI_WIDTH-1:0] ci_ev;
  assign ci_ev[`CI_VBUS_ERR] = host_mode_r & vbus_s & ~vbus_d_r;
  assign ci_ev[`CI_DISCONNECT] = host_mode_r & attach_fall;
  assign ci_ev[`CI_CONNECT] = host_mode_r & attach_rise;
  assign ci_ev[`CI_SOF] = sof_i;
  assign ci_ev[`CI_BABBLE] = host_mode_r & babble_s;
  assign ci_ev[`CI_RESUME] = rres_s & ~rres_d_r;
  assign ci_ev[`CI_POWER_FAULT] = pflt_lvl & ~pflt_d_r;
  assign ci_ev[`CI_STATUS_DONE] = status_done_i & status_req_o;

  wire [`EP_COUNT-1:0] ep_ev = in_done_i & in_pending_o;

  // slave: one wait cycle, then the answer
  // registered, so the master never sees a decode glitch
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      avs_waitrequest_o <= 1'b1;
    else if (ce_i)
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
  end

  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      host_mode_r <= 1'b0;
      pflt_en_r <= 1'b0;
      pflt_pol_r <= 1'b0;
      reset_flag_r <= 1'b0;
      resume_flag_r <= 1'b0;
      cie_r <= {`CI_WIDTH{1'b0}};
      eie_r <= {`EP_COUNT{1'b0}};
      buf_sel_r <= 3'h0;
    end
    else if (ce_i)
    begin
      if (wr_mode)
      begin
        host_mode_r <= wd[`MODE_HOST_BIT];
        pflt_en_r <= wd[`MODE_PFLT_EN_BIT];
        pflt_pol_r <= wd[`MODE_PFLT_POL_BIT];
      end
      if (wr_sig)
      begin
        reset_flag_r <= wd[`SIG_RESET_BIT];
        resume_flag_r <= wd[`SIG_RESUME_BIT];
      end
      if (wr_cie_set)
        cie_r <= cie_r | wd[`CI_WIDTH-1:0];
      if (wr_cie_clr)
        cie_r <= cie_r & ~wd[`CI_WIDTH-1:0];
      if (wr_eie_set)
        eie_r <= eie_r | wd[`EP_COUNT-1:0];
      if (wr_eie_clr)
        eie_r <= eie_r & ~wd[`EP_COUNT-1:0];
      if (wr_indata)
        buf_sel_r <= wd[2:0];
    end
  end

  // edge history for the attach, vbus and resume pins and the power fault level
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      attach_d_r <= 1'b0;
      pflt_d_r <= 1'b0;
      vbus_d_r <= 1'b0;
      rres_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      attach_d_r <= attach_s;
      pflt_d_r <= pflt_lvl;
      vbus_d_r <= vbus_s;
      rres_d_r <= rres_s;
    end
  end

  // sticky flags; a new event in the clearing read wins
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cis_r <= {`CI_WIDTH{1'b0}};
      eis_r <= {`EP_COUNT{1'b0}};
    end
    else if (ce_i)
    begin
      cis_r <= (rd_cis ? {`CI_WIDTH{1'b0}} : cis_r) | ci_ev;
      eis_r <= (rd_eis ? {`EP_COUNT{1'b0}} : eis_r) | ep_ev;
    end
  end

  // IN queue per endpoint; generate gives each slot its own logic
  genvar g;
  generate
    for (g = 0; g < `EP_COUNT; g = g + 1)
    begin : g_ep
      always @(posedge sys_clk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          in_pending_o[g] <= 1'b0;
          ep_buf_r[g] <= 32'h0;
        end
        else if (ce_i)
        begin
          if (wr_inreq & wd[g] & host_mode_r)
            in_pending_o[g] <= 1'b1;
          else if (wr_inclr & wd[g])
            in_pending_o[g] <= 1'b0;
          else if (in_done_i[g])
            in_pending_o[g] <= 1'b0;
          if (ep_ev[g])
            ep_buf_r[g] <= in_data_i;
        end
      end
    end
  endgenerate

  // resume sequence: drive while flag set, finish one cycle after clear
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      resume_st_r <= RS_IDLE;
    else if (ce_i)
    begin
      case (resume_st_r)
        RS_IDLE:
          if (resume_flag_r)
            resume_st_r <= RS_DRIVE;
        RS_DRIVE:
          if (!resume_flag_r)
            resume_st_r <= RS_FINISH;
        RS_FINISH:
          resume_st_r <= RS_IDLE;
        default:
          resume_st_r <= RS_IDLE;
      endcase
    end
  end

  // bus-facing outputs, all registered
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      status_req_o <= 1'b0;
      bus_reset_o <= 1'b0;
      bus_resume_o <= 1'b0;
      bus_suspend_o <= 1'b0;
      dma_req_o <= 1'b0;
      dma_data_o <= 32'h0;
      speed_o <= `SPEED_UNKNOWN;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // endpoint zero only: the command carries no endpoint field
      if (wr_cmd & wd[`CMD_STATUS_REQ_BIT] & host_mode_r)
        status_req_o <= 1'b1;
      else if (status_done_i)
        status_req_o <= 1'b0;
      bus_reset_o <= host_mode_r & reset_flag_r;
      // resume in device mode follows the flag; software owns timing
      bus_resume_o <= resume_flag_r;
      if (!host_mode_r || resume_flag_r || reset_flag_r)
        bus_suspend_o <= 1'b0;
      else if (wr_cmd & wd[`CMD_SUSPEND_BIT])
        bus_suspend_o <= 1'b1;
      dma_req_o <= |ep_ev;
      if (|ep_ev)
        dma_data_o <= in_data_i;
      if (!host_mode_r || attach_fall)
        speed_o <= `SPEED_UNKNOWN;
      else if (attach_rise)
        speed_o <= speed_s;
      irq_o <= |(cis_r & cie_r) | |(eis_r & eie_r);
    end
  end

  // read data, answered in the cycle waitrequest is low
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      avs_readdata_o <= 32'h0;
    else if (ce_i && avs_read_i && avs_waitrequest_o)
    begin
      case (avs_address_i)
        `OFS_MODE: avs_readdata_o <= {29'h0, pflt_pol_r, pflt_en_r,
          host_mode_r};
        `OFS_SIGNAL: avs_readdata_o <= {30'h0, resume_flag_r, reset_flag_r};
        `OFS_STATUS: avs_readdata_o <= {25'h0, pflt_lvl, bus_suspend_o,
          bus_resume_o | (resume_st_r == RS_FINISH), status_req_o,
          attach_s, speed_o};
        `OFS_INREQ: avs_readdata_o <= {24'h0, in_pending_o};
        `OFS_CIE_SET: avs_readdata_o <= {24'h0, cie_r};
        `OFS_EIE_SET: avs_readdata_o <= {24'h0, eie_r};
        `OFS_CIS: avs_readdata_o <= {24'h0, cis_r | ci_ev};
        `OFS_EIS: avs_readdata_o <= {24'h0, eis_r | ep_ev};
        `OFS_INDATA: avs_readdata_o <= ep_buf_r[buf_sel_r];
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end
endmodule

// ==== verif/usb_host_ctrl_asserts.sv ====
`timescale 1ns/1ps
`include "usb_host_ctrl_defines.vh"
module usb_host_ctrl_asserts (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // register bus
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire avs_waitrequest_o,
  // engine side
  input wire [7:0] in_done_i,
  input wire [31:0] in_data_i,
  input wire status_done_i,
  input wire [7:0] in_pending_o,
  input wire status_req_o,
  input wire bus_reset_o,
  input wire bus_suspend_o,
  input wire dma_req_o,
  input wire [31:0] dma_data_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  reg mode_r;
  wire tk = avs_write_i && !avs_waitrequest_o;
  wire cmd_wr = tk && avs_address_i == `OFS_CMD;
  wire mode_wr = tk && avs_address_i == `OFS_MODE;
  // host bit as software last wrote it, seen only from the bus
  always @(posedge sys_clk_i or posedge reset_i)
    if (reset_i)
      mode_r <= 1'b0;
    else if (mode_wr)
      mode_r <= avs_writedata_i[0];
  sequence s_req_up;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence s_in_rise;
    |(in_pending_o & ~$past(in_pending_o));
  endsequence
  AST_WAIT_ANSWER: assert property (s_req_up |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  AST_IN_QUEUE: assert property (s_in_rise |->
    $past(tk && avs_address_i == `OFS_INREQ && mode_r))
    else $error("IN queued without host request");
  AST_IN_CANCEL: assert property (
    |($past(in_pending_o) & ~in_pending_o) |-> $past(mode_wr ||
    |in_done_i || tk && avs_address_i == `OFS_INCLR))
    else $error("queued IN dropped without cause");
  AST_DMA_DATA: assert property (|(in_done_i & in_pending_o) |=>
    dma_req_o && dma_data_o == $past(in_data_i))
    else $error("returned data not offered to DMA");
  AST_STATUS_REQ: assert property ($rose(status_req_o) |->
    $past(cmd_wr && avs_writedata_i[0] && mode_r))
    else $error("status request without command");
  AST_STATUS_DONE: assert property (
    status_req_o && status_done_i |=> !status_req_o)
    else $error("status request outlives status packet");
  AST_RESET_HOST: assert property (
    bus_reset_o |-> mode_r || $past(mode_r))
    else $error("bus reset outside host mode");
  AST_SUSPEND: assert property ($rose(bus_suspend_o) |->
    $past(cmd_wr && avs_writedata_i[1] && mode_r))
    else $error("suspend without host command");
endmodule
bind usb_host_ctrl usb_host_ctrl_asserts u_chk (
  .sys_clk_i(sys_clk_i),
  .reset_i(reset_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .in_done_i(in_done_i),
  .in_data_i(in_data_i),
  .status_done_i(status_done_i),
  .in_pending_o(in_pending_o),
  .status_req_o(status_req_o),
  .bus_reset_o(bus_reset_o),
  .bus_suspend_o(bus_suspend_o),
  .dma_req_o(dma_req_o),
  .dma_data_o(dma_data_o)
);

// ==== verif/usb_dev_model.sv ====
`timescale 1ns/1ps
module usb_dev_model (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // requests and answer delay
  input wire [7:0] delay_i,
  input wire [7:0] in_pending_i,
  input wire status_req_i,
  // answers
  output reg [7:0] in_done_o,
  output reg [31:0] in_data_o,
  output reg status_done_o
);
  reg [7:0] cnt_r;
  // lowest pending endpoint is served first
  wire [7:0] pick = in_pending_i & (~in_pending_i + 8'h01);
  // rest a cycle after each answer so the host can drop its request
  always @(posedge sys_clk_i or posedge reset_i)
    if (reset_i)
    begin
      cnt_r <= 8'h00;
      in_done_o <= 8'h00;
      in_data_o <= 32'h0;
      status_done_o <= 1'b0;
    end
    else
    begin
      in_done_o <= 8'h00;
      status_done_o <= 1'b0;
      in_data_o <= ~in_data_o;
      if (|in_done_o || status_done_o || !(|in_pending_i || status_req_i))
        cnt_r <= 8'h00;
      else if (cnt_r < delay_i)
        cnt_r <= cnt_r + 8'h01;
      else if (|pick)
      begin
        in_done_o <= pick;
        in_data_o <= {8'h5a, 16'h0, pick};
      end
      else
        status_done_o <= 1'b1;
    end
endmodule

// ==== verif/tb_usb_host_ctrl.sv ====
`timescale 1ns/1ps
`include "usb_host_ctrl_defines.vh"
module tb_usb_host_ctrl;
  logic sys_clk_i, reset_i, avs_read_i, avs_write_i, sof_i;
  logic [7:0] avs_address_i, dly, in_done_i, in_pending_o;
  logic [31:0] avs_writedata_i, rdv, avs_readdata_o, in_data_i;
  logic [31:0] dma_data_o;
  logic avs_waitrequest_o, status_done_i, dev_attach_i, irq_o;
  logic power_fault_input_i, status_req_o, bus_reset_o;
  logic bus_resume_o, bus_suspend_o, dma_req_o;
  logic [1:0] dev_speed_i, speed_o;
  // clock enable has a freeze scenario; pins without a scenario of their own are held quiet
  logic ce_i;
  wire [3:0] avs_byteenable_i = 4'hf;
  wire vbus_err_i = 1'b0;
  wire babble_i = 1'b0;
  wire remote_resume_i = 1'b0;
  integer mismatches = 0;
  integer num_checks = 0;
  integer i;
  usb_host_ctrl DUT (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .power_fault_input_i(power_fault_input_i),
    .dev_speed_i(dev_speed_i),
    .dev_attach_i(dev_attach_i),
    .vbus_err_i(vbus_err_i),
    .babble_i(babble_i),
    .remote_resume_i(remote_resume_i),
    .sof_i(sof_i),
    .in_done_i(in_done_i),
    .in_data_i(in_data_i),
    .status_done_i(status_done_i),
    .in_pending_o(in_pending_o),
    .status_req_o(status_req_o),
    .bus_reset_o(bus_reset_o),
    .bus_resume_o(bus_resume_o),
    .bus_suspend_o(bus_suspend_o),
    .dma_req_o(dma_req_o),
    .dma_data_o(dma_data_o),
    .speed_o(speed_o),
    .irq_o(irq_o)
  );
  usb_dev_model u_dev (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .delay_i(dly), .in_pending_i(in_pending_o),
    .status_req_i(status_req_o), .in_done_o(in_done_i),
    .in_data_o(in_data_i), .status_done_o(status_done_i));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e)
      begin
        $display("[ERR] %s exp %h got %h", nm, e, s);
        mismatches = mismatches + 1;
      end
    end
  endtask
  task bound(input integer n);
    if (n > 400)
    begin
      mismatches = mismatches + 1;
      complete_run;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
    end
  endtask
  // one bus access; the request stands until waitrequest is seen low
  task acc(input logic w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      n = 0;
      // waitrequest and read data are taken at the rising edge itself
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0)
      begin
        n = n + 1;
        bound(n);
        @(posedge sys_clk_i);
      end
      rdv = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(negedge sys_clk_i);
    end
  endtask
  task idle;
    integer n;
    begin
      n = 0;
      while (!(in_pending_o === 8'h00 && status_req_o === 1'b0))
      begin
        n = n + 1;
        bound(n);
        @(negedge sys_clk_i);
      end
    end
  endtask
  initial
  begin
    reset_i = 1'b1;
    {avs_read_i, avs_write_i, sof_i, dev_attach_i} = 4'h0;
    ce_i = 1'b1;
    {avs_address_i, avs_writedata_i, dev_speed_i} = 42'h0;
    power_fault_input_i = 1'b0;
    dly = 8'h02;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    cyc(1);
    chk("speed", speed_o, `SPEED_UNKNOWN);
    acc(1, `OFS_INREQ, 32'h1);
    acc(1, `OFS_SIGNAL, 32'h1);
    cyc(2);
    chk("pending", in_pending_o, 32'h0);
    chk("reset", bus_reset_o, 32'h0);
    acc(1, `OFS_MODE, 32'h1);
    cyc(2);
    chk("reset", bus_reset_o, 32'h1);
    acc(1, `OFS_SIGNAL, 32'h0);
    acc(1, `OFS_CMD, 32'h2);
    cyc(2);
    chk("reset", bus_reset_o, 32'h0);
    chk("suspend", bus_suspend_o, 32'h1);
    acc(1, `OFS_SIGNAL, 32'h2);
    cyc(2);
    chk("resume", bus_resume_o, 32'h1);
    chk("suspend", bus_suspend_o, 32'h0);
    acc(1, `OFS_SIGNAL, 32'h0);
    cyc(2);
    chk("resume", bus_resume_o, 32'h0);
    acc(1, `OFS_MODE, 32'h0);
    acc(1, `OFS_SIGNAL, 32'h2);
    cyc(2);
    chk("resume", bus_resume_o, 32'h1);
    acc(1, `OFS_SIGNAL, 32'h0);
    acc(1, `OFS_CMD, 32'h3);
    cyc(2);
    chk("resume", bus_resume_o, 32'h0);
    chk("suspend", bus_suspend_o, 32'h0);
    chk("statreq", status_req_o, 32'h0);
    acc(1, `OFS_MODE, 32'h1);
    for (i = 1; i < 4; i = i + 1)
    begin
      @(posedge sys_clk_i);
      dev_speed_i <= i[1:0];
      dev_attach_i <= 1'b1;
      cyc(8);
      chk("speed", speed_o, i);
      @(posedge sys_clk_i);
      dev_attach_i <= 1'b0;
      cyc(8);
      chk("speed", speed_o, 32'h0);
    end
    acc(1, `OFS_CIE_SET, 32'hff);
    acc(1, `OFS_CIE_CLR, 32'h0f);
    acc(1, `OFS_EIE_SET, 32'h81);
    acc(1, `OFS_EIE_CLR, 32'h01);
    acc(0, `OFS_CIE_SET, 32'h0);
    chk("cie", rdv, 32'hf0);
    acc(0, `OFS_EIE_SET, 32'h0);
    chk("eie", rdv, 32'h80);
    acc(0, `OFS_CIS, 32'h0);
    @(posedge sys_clk_i);
    sof_i <= 1'b1;
    @(posedge sys_clk_i);
    sof_i <= 1'b0;
    cyc(3);
    chk("irq", irq_o, 32'h0);
    acc(1, `OFS_CIE_SET, 32'h08);
    cyc(2);
    chk("irq", irq_o, 32'h1);
    acc(0, `OFS_CIS, 32'h0);
    chk("cis", rdv, 32'h08);
    acc(0, `OFS_CIS, 32'h0);
    chk("cis", rdv, 32'h0);
    chk("irq", irq_o, 32'h0);
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    sof_i <= 1'b1;
    @(posedge sys_clk_i);
    sof_i <= 1'b0;
    ce_i <= 1'b1;
    acc(0, `OFS_CIS, 32'h0);
    chk("frozen", rdv, 32'h0);
    acc(1, `OFS_INREQ, 32'h05);
    idle;
    chk("dmareq", dma_req_o, 32'h1);
    chk("dmadata", dma_data_o, 32'h5a000004);
    chk("irq", irq_o, 32'h0);
    acc(0, `OFS_EIS, 32'h0);
    chk("eis", rdv, 32'h05);
    acc(1, `OFS_INDATA, 32'h2);
    acc(0, `OFS_INDATA, 32'h0);
    chk("indata", rdv, 32'h5a000004);
    acc(0, `OFS_EIS, 32'h0);
    chk("eis", rdv, 32'h0);
    dly <= 8'd200;
    acc(1, `OFS_INREQ, 32'h10);
    chk("pending", in_pending_o, 32'h10);
    acc(1, `OFS_INCLR, 32'h10);
    chk("pending", in_pending_o, 32'h0);
    cyc(250);
    acc(0, `OFS_EIS, 32'h0);
    chk("eis", rdv, 32'h0);
    dly <= 8'h02;
    acc(1, `OFS_CMD, 32'h1);
    chk("statreq", status_req_o, 32'h1);
    idle;
    acc(0, `OFS_CIS, 32'h0);
    chk("cis", rdv, 32'h80);
    @(posedge sys_clk_i);
    power_fault_input_i <= 1'b1;
    cyc(6);
    acc(0, `OFS_CIS, 32'h0);
    chk("fault", rdv, 32'h0);
    @(posedge sys_clk_i);
    power_fault_input_i <= 1'b0;
    cyc(6);
    acc(1, `OFS_MODE, 32'h3);
    @(posedge sys_clk_i);
    power_fault_input_i <= 1'b1;
    cyc(6);
    acc(0, `OFS_CIS, 32'h0);
    chk("fault", rdv, 32'h40);
    acc(0, `OFS_STATUS, 32'h0);
    chk("status", rdv, 32'h40);
    acc(1, `OFS_MODE, 32'h7);
    @(posedge sys_clk_i);
    power_fault_input_i <= 1'b0;
    cyc(6);
    acc(0, `OFS_CIS, 32'h0);
    chk("faultpol", rdv, 32'h40);
    acc(0, 8'hfc, 32'h0);
    chk("unmapped", rdv, 32'h0);
    complete_run;
  end
endmodule
